// [dv/rsa_assertions.sv]
// Port checks for the slave access engine.
// Assumes it is bound to rsa_slave_access and gets WR_CYCLES from it.
`timescale 1ns/1ps
module rsa_checker #(
  parameter int WR_CYCLES = 50
)(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic protect_upper,
  input wire logic nv_busy,
  input wire logic [15:0] addr_cnt
);
  // --------------------------------------------------
  // Helper: length of the current busy period
  // --------------------------------------------------
  logic [31:0] busy_len_q;
  always_ff @(posedge ref_clk) begin
    if (rst || !nv_busy) begin
      busy_len_q <= '0;
    end else begin
      busy_len_q <= busy_len_q + 32'h1;
    end
  end
  // --------------------------------------------------
  // Assertions
  // --------------------------------------------------
  a_out_low: assert property (
    @(posedge ref_clk) disable iff (rst) sda_out == 1'b0)
    else $error("sda_out left its fixed low value");
  a_busy_no_ack: assert property (
    @(posedge link_clk) disable iff (rst) nv_busy |-> !sda_oe)
    else $error("line pulled during write cycle");
  a_busy_length: assert property (
    @(posedge ref_clk) disable iff (rst) $fell(nv_busy) |-> busy_len_q == WR_CYCLES)
    else $error("write cycle length wrong");
  a_reset_idle: assert property (
    @(posedge link_clk) disable iff (rst) $fell(rst) |-> addr_cnt == 16'h0000 && !sda_oe)
    else $error("link side not cleared by reset");
  a_busy_reset: assert property (
    @(posedge ref_clk) disable iff (rst) $fell(rst) |-> !nv_busy)
    else $error("busy set after reset");
  a_drive_scl_low: assert property (
    @(posedge link_clk) disable iff (rst) $changed(sda_oe) |-> !scl_in)
    else $error("sda changed while scl high");
  a_cnt_hold_busy: assert property (
    @(posedge link_clk) disable iff (rst) nv_busy && $past(nv_busy) |-> $stable(addr_cnt))
    else $error("counter moved during write cycle");
  a_cnt_range: assert property (
    @(posedge link_clk) disable iff (rst) addr_cnt <= 16'h01FF)
    else $error("counter beyond address space");
  c_busy: cover property (@(posedge ref_clk) $rose(nv_busy));
  c_prot_ack: cover property (@(posedge link_clk) protect_upper && $rose(sda_oe));
  c_wrap: cover property (@(posedge link_clk) $past(addr_cnt) == 16'h01FF && addr_cnt == 16'h0000);
endmodule

bind rsa_slave_access rsa_checker #(.WR_CYCLES(WR_CYCLES)) u_rsa_checker (
  .ref_clk(ref_clk), .rst(rst), .link_clk(link_clk), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .protect_upper(protect_upper), .nv_busy(nv_busy),
  .addr_cnt(addr_cnt)
);

// [dv/rsa_master_model.sv]
// Two-wire bus master model with byte level tasks.
// Assumes sda_wire is the wired-AND line with a pull-up.
`timescale 1ns/1ps
module rsa_master_model (
  input wire logic clk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_m
);
  // Quarter bit; scl stays well below a quarter of the link rate
  localparam int Q = 12;
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic clk_bit(input logic b, output logic s);
    sda_m = b;
    tick(Q);
    scl = 1'b1;
    tick(Q);
    s = sda_wire;
    tick(Q);
    scl = 1'b0;
    tick(Q);
  endtask
  task automatic start();
    sda_m = 1'b1;
    tick(Q);
    scl = 1'b1;
    tick(Q);
    sda_m = 1'b0;
    tick(Q);
    scl = 1'b0;
    tick(Q);
  endtask
  task automatic stop();
    sda_m = 1'b0;
    tick(Q);
    scl = 1'b1;
    tick(Q);
    sda_m = 1'b1;
    tick(2 * Q);
  endtask
  // Fewer than eight bits leaves the byte cut short
  task automatic wr_byte(input logic [7:0] d, input int nbits, output logic ack);
    logic s;
    ack = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      clk_bit(d[7-i], s);
    end
    if (nbits == 8) begin
      clk_bit(1'b1, s);
      ack = ~s;
    end
  endtask
  task automatic rd_byte(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 0; i < 8; i++) begin
      clk_bit(1'b1, d[7-i]);
    end
    clk_bit(~mack, s);
  endtask
endmodule

// [dv/testbench.sv]
// Self-checking bench for the slave access engine.
// Assumes the master model is the only other party on the line.
`timescale 1ns/1ps
module testbench;
  import rsa_pkg::*;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic protect_upper = 1'b0;
  logic scl, sda_m, sda_wire, sda_out, sda_oe, nv_busy, ack, b;
  logic [15:0] addr_cnt;
  logic [7:0] arr_m [512];
  logic [7:0] reg_m [64];
  logic [7:0] slv_list [8] = '{8'hAE, 8'hDE, 8'hA0, 8'hAC, 8'hDA, 8'hBE, 8'h5E, 8'hEE};
  logic [7:0] sb;
  int n_fail = 0;
  int tests_run = 0;
  int cnt_m;
  // Status register offset; value is arbitrary, the design does not decode it
  localparam int STAT_REG = 63;
  assign sda_wire = sda_m & ~(sda_oe & ~sda_out);
  always #12.5 ref_clk = ~ref_clk;
  initial begin
    #7;
    forever #62.5 link_clk = ~link_clk;
  end
  rsa_slave_access #(.WR_CYCLES(800)) u_rsa_slave_access (
    .ref_clk(ref_clk), .rst(rst), .link_clk(link_clk), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .protect_upper(protect_upper), .nv_busy(nv_busy),
    .addr_cnt(addr_cnt)
  );
  rsa_master_model u_mst (.clk(ref_clk), .sda_wire(sda_wire), .scl(scl), .sda_m(sda_m));
  // --------------------------------------------------
  // Compare and report
  // --------------------------------------------------
  task automatic chk_v(input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: expected %0h got %0h", $time, e, g);
    end
  endtask
  task automatic chk_b(input logic e, input logic g);
    chk_v({15'h0000, e}, {15'h0000, g});
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // --------------------------------------------------
  // Transactions
  // --------------------------------------------------
  task automatic poll();
    logic pa;
    pa = 1'b0;
    for (int k = 0; k < 20 && !pa; k++) begin
      u_mst.start();
      u_mst.wr_byte(8'hAE, 8, pa);
      if (k == 0) chk_b(1'b0, pa);
      u_mst.stop();
    end
    chk_b(1'b1, pa);
    if (!pa) results();
  endtask
  // Byte or page write; part > 0 cuts one more byte short before the stop
  task automatic wr(input logic [7:0] slv, input logic [15:0] a, input int n, input int part);
    logic [7:0] d;
    int rs, pm, am, col, base, commit;
    rs = (slv[7:4] == CCR_ID);
    pm = rs ? 8 : 16;
    am = a & (rs ? 63 : 511);
    base = am & ~(pm - 1);
    col = am % pm;
    commit = n > 0 && part == 0 && !(!rs && protect_upper && am >= 256);
    if (rs && n == 1 && am >= 8 && am < 16) commit = 0;
    u_mst.start();
    u_mst.wr_byte(slv, 8, ack);
    chk_b(1'b1, ack);
    u_mst.wr_byte(a[15:8], 8, ack);
    chk_b(1'b1, ack);
    u_mst.wr_byte(a[7:0], 8, ack);
    chk_b(1'b1, ack);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      u_mst.wr_byte(d, 8, ack);
      chk_b(1'b1, ack);
      if (commit && rs) reg_m[base+col] = d;
      if (commit && !rs) arr_m[base+col] = d;
      col = (col + 1) % pm;
    end
    if (part > 0) u_mst.wr_byte(8'($urandom), part, ack);
    u_mst.stop();
    u_mst.tick(8);
    chk_b(commit[0], nv_busy);
    if (part == 0) begin
      cnt_m = base + col;
      chk_v(16'(cnt_m), addr_cnt);
    end
    if (commit) poll();
  endtask
  task automatic rd(input logic [7:0] slv, input logic rnd, input logic [15:0] a, input int n);
    logic [7:0] d;
    int m;
    m = (slv[7:4] == CCR_ID) ? 63 : 511;
    u_mst.start();
    if (rnd) begin
      u_mst.wr_byte({slv[7:1], 1'b0}, 8, ack);
      u_mst.wr_byte(a[15:8], 8, ack);
      u_mst.wr_byte(a[7:0], 8, ack);
      chk_b(1'b1, ack);
      u_mst.start();
      cnt_m = a & m;
    end
    u_mst.wr_byte(slv, 8, ack);
    chk_b(1'b1, ack);
    for (int i = 0; i < n; i++) begin
      u_mst.rd_byte(i < n - 1, d);
      sb = (m == 63) ? reg_m[cnt_m] : arr_m[cnt_m];
      if (!$isunknown(sb)) chk_v({8'h00, sb}, {8'h00, d});
      cnt_m = (cnt_m + 1) & m;
    end
    u_mst.stop();
    chk_v(16'(cnt_m), addr_cnt);
  endtask
  // --------------------------------------------------
  // Main sequence
  // --------------------------------------------------
  initial begin
    void'($urandom(41466));
    // Held past four link cycles so the link side sees it
    repeat (32) @(negedge ref_clk);
    rst = 1'b0;
    u_mst.tick(40);
    chk_v(16'h0000, addr_cnt);
    rd(8'hAF, 1'b0, 16'h0000, 1);
    for (int i = 0; i < 10; i++) begin
      sb = (i < 8) ? slv_list[i] : {7'($urandom), 1'b0};
      b = sb[7:1] == {ARR_ID, DEV_SEL} || sb[7:1] == {CCR_ID, DEV_SEL};
      u_mst.start();
      u_mst.wr_byte(sb, 8, ack);
      chk_b(b, ack);
      u_mst.stop();
    end
    wr(8'hAE, 16'h000A, 15, 0);
    wr(8'hAE, 16'h001A, 18, 0);
    wr(8'hAE, 16'h01F0, 16, 0);
    rd(8'hAF, 1'b1, 16'h01FE, 4);
    rd(8'hAF, 1'b1, 16'h0018, 4);
    protect_upper = 1'b1;
    wr(8'hAE, 16'h01F3, 2, 0);
    rd(8'hAF, 1'b1, 16'h01F2, 3);
    protect_upper = 1'b0;
    wr(8'hAE, 16'h01F4, 1, 4);
    rd(8'hAF, 1'b1, 16'h01F4, 1);
    wr(8'hAE, 16'h0002, 0, 0);
    rd(8'hAF, 1'b0, 16'h0000, 2);
    // Writes of 02 then 06 to STAT_REG before register writes: two separate operations, not decoded by the design
    for (int i = 0; i < 2; i++) begin
      u_mst.start();
      u_mst.wr_byte(8'hDE, 8, ack);
      u_mst.wr_byte(8'h00, 8, ack);
      u_mst.wr_byte(8'(STAT_REG), 8, ack);
      u_mst.wr_byte((i == 0) ? 8'h02 : 8'h06, 8, ack);
      chk_b(1'b1, ack);
      u_mst.stop();
      reg_m[STAT_REG] = (i == 0) ? 8'h02 : 8'h06;
      u_mst.tick(8);
      poll();
    end
    wr(8'hDE, 16'h0033, 10, 0);
    rd(8'hDF, 1'b1, 16'h0030, 8);
    wr(8'hDE, 16'h0009, 1, 0);
    wr(8'hDE, 16'h0008, 2, 0);
    rd(8'hDF, 1'b1, 16'h0008, 2);
    results();
  end
endmodule

// [src/rsa_pkg.sv]
// Shared constants for the serial slave access engine.
// Assumes a 40 MHz ref_clk; the link side runs on its own sampling clock.
package rsa_pkg;

  // ------------------------------------------------------------
  // Slave address byte
  // ------------------------------------------------------------
  localparam logic [3:0] ARR_ID = 4'hA;
  localparam logic [3:0] CCR_ID = 4'hD;
  localparam logic [2:0] DEV_SEL = 3'h7;

  // ------------------------------------------------------------
  // Address space and pages
  // ------------------------------------------------------------
  localparam int ARR_AW = 9;
  localparam int CCR_AW = 6;
  localparam int PAGE_MAX = 16;
  localparam int CCR_PAGE = 8;
  localparam logic [15:0] ARR_MASK = 16'h01FF;
  localparam logic [15:0] CCR_MASK = 16'h003F;
  localparam logic [15:0] ARR_PMASK = 16'h000F;
  localparam logic [15:0] CCR_PMASK = 16'h0007;
  localparam logic [15:0] ADDR_ONE = 16'h0001;
  localparam logic [15:0] PROT_BASE = 16'h0100;
  localparam logic [15:0] ALM_PAGE = 16'h0008;

  // ------------------------------------------------------------
  // Non-volatile write cycle timing
  // ------------------------------------------------------------
  localparam int WR_TIME_MS = 5;
  localparam int REF_MHZ = 40;
  localparam int WR_CYCLES_DFLT = WR_TIME_MS * REF_MHZ * 1000;

  // ------------------------------------------------------------
  // Link sequencing
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_RX = 3'b001,
    PH_ACK = 3'b010,
    PH_TX = 3'b011,
    PH_MACK = 3'b100
  } rsa_phase_type;

  typedef enum logic [1:0] {
    K_SLV = 2'b00,
    K_AHI = 2'b01,
    K_ALO = 2'b10,
    K_DAT = 2'b11
  } rsa_kind_type;

endpackage

// [src/rsa_slave_access.sv]
// Serial slave access engine: slave address decode, word addressing,
// byte and page writes, acknowledge polling, current and random reads.
// Assumes scl/sda pins are asynchronous and link_clk runs freely,
// several times faster than the serial clock.
`timescale 1ns/1ps
// Contract
// - Nibble 1010 array, 1101 registers; bit0 reads.
// - Device select bits are fixed at 111.
// - Acknowledge only 1010111 or 1101111 slave bytes.
// - Two word address bytes, else internal counter.
// - Address counter clears to zero at reset.
// - Byte write acked; stop starts write cycle.
// - Busy write cycle: no acknowledge, line released.
// - Protected write acked, no cycle, still acking.
// - Single byte never commits alarm registers.
// - Pages hold 16 array or 8 register bytes.
// - Page write increments, wrapping within page.
// - Extra bytes overwrite earlier; stop starts write.
// - Stop mid-byte or before data aborts write.
// - Withhold array and register slave acknowledge while busy.
// - Counter holds last read plus one.
// - Random read: dummy write, restart, read.
// - Stop after address loads counter, standby.
// - Keep sending while master acknowledges.
// - Read counter wraps at end of space.
module rsa_slave_access
  import rsa_pkg::*;
#(
  parameter int WR_CYCLES = WR_CYCLES_DFLT
)(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic protect_upper,
  output logic nv_busy,
  output logic [15:0] addr_cnt
);
  if (WR_CYCLES < 1) begin : g_bad_cycles
    $error("rsa_slave_access: WR_CYCLES must be at least 1");
  end

  // ------------------------------------------------------------
  // State types
  // ------------------------------------------------------------
  typedef struct packed {
    logic scl_p;
    logic sda_p;
    rsa_phase_type ph;
    rsa_kind_type kind;
    logic [2:0] bit_cnt;
    logic rx_done;
    logic [7:0] sh;
    logic [15:0] addr;
    logic [7:0] ahi;
    logic sec;
    logic rw;
    logic [1:0] dcnt;
    logic [8*PAGE_MAX-1:0] pbuf;
    logic [PAGE_MAX-1:0] pmask;
    logic [15:0] pbase;
    logic oe;
    logic pend;
    logic tgl;
  } rsa_link_type;

  typedef struct packed {
    logic tgl_p;
  } rsa_ref_type;

  localparam rsa_link_type LINK_RST = '{
    scl_p: 1'b1,
    sda_p: 1'b1,
    ph: PH_IDLE,
    kind: K_SLV,
    default: '0
  };

  rsa_link_type l_q;
  rsa_link_type l_d;
  rsa_ref_type r_q;
  rsa_ref_type r_d;

  logic [7:0] arr_mem [2**ARR_AW];
  logic [7:0] ccr_mem [2**CCR_AW];

  // ------------------------------------------------------------
  // Crossings
  // ------------------------------------------------------------
  logic link_rst;
  logic scl_s;
  logic sda_s;
  logic prot_s;
  logic busy_s;
  logic tgl_s;
  logic tmr_busy;
  logic wr_start;

  rsa_sync #(.W(1), .RST_VAL(1'b1)) u_rst_sync (
    .clk(link_clk),
    .rst(1'b0),
    .d(rst),
    .q(link_rst)
  );

  // Pins idle high, so they reset high to avoid a false start
  rsa_sync #(.W(4), .RST_VAL(4'h3)) u_pin_sync (
    .clk(link_clk),
    .rst(link_rst),
    .d({tmr_busy, protect_upper, scl_in, sda_in}),
    .q({busy_s, prot_s, scl_s, sda_s})
  );

  rsa_sync #(.W(1), .RST_VAL(1'b0)) u_tgl_sync (
    .clk(ref_clk),
    .rst(rst),
    .d(l_q.tgl),
    .q(tgl_s)
  );

  // ------------------------------------------------------------
  // Write cycle timer, device clock side
  // ------------------------------------------------------------
  always_comb begin
    r_d.tgl_p = tgl_s;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign wr_start = tgl_s ^ r_q.tgl_p;

  rsa_wtimer #(.CYCLES(WR_CYCLES)) u_wtimer (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(wr_start),
    .busy(tmr_busy)
  );

  assign nv_busy = tmr_busy;

  // ------------------------------------------------------------
  // Link decode helpers
  // ------------------------------------------------------------
  logic rise;
  logic fall;
  logic start_c;
  logic stop_c;
  logic busy_l;
  logic id_arr;
  logic id_ccr;
  logic [15:0] smask;
  logic [15:0] pgmask;
  logic [15:0] rd_next;
  logic [15:0] wr_next;
  logic [15:0] full_addr;
  logic [3:0] off;
  logic [7:0] rd_byte;
  logic prot;
  logic alarm;
  logic wr_ok;

  assign rise = scl_s & ~l_q.scl_p;
  assign fall = ~scl_s & l_q.scl_p;
  assign start_c = scl_s & l_q.scl_p & l_q.sda_p & ~sda_s;
  assign stop_c = scl_s & l_q.scl_p & ~l_q.sda_p & sda_s;
  // Pending covers the gap before the timer's busy reaches this domain
  assign busy_l = l_q.pend | busy_s;
  assign id_arr = (l_q.sh[7:4] == ARR_ID) && (l_q.sh[3:1] == DEV_SEL);
  assign id_ccr = (l_q.sh[7:4] == CCR_ID) && (l_q.sh[3:1] == DEV_SEL);
  assign smask = l_q.sec ? CCR_MASK : ARR_MASK;
  assign pgmask = l_q.sec ? CCR_PMASK : ARR_PMASK;
  assign rd_next = (l_q.addr + ADDR_ONE) & smask;
  assign wr_next = (l_q.addr & ~pgmask) | ((l_q.addr + ADDR_ONE) & pgmask);
  assign full_addr = {l_q.ahi, l_q.sh} & smask;
  assign off = l_q.addr[3:0] & pgmask[3:0];
  assign rd_byte = l_q.sec ? ccr_mem[l_q.addr[CCR_AW-1:0]] : arr_mem[l_q.addr[ARR_AW-1:0]];
  assign prot = ~l_q.sec & prot_s & (l_q.pbase >= PROT_BASE);
  assign alarm = l_q.sec & (l_q.pbase == ALM_PAGE);

  // Commit only on a byte boundary after a full data byte and its ack.
  // The stop's own scl rise is shifted in as one bit, so a clean stop
  // shows exactly one bit; more means the stop cut a data byte.
  assign wr_ok = (l_q.ph == PH_RX) && (l_q.kind == K_DAT) && ~l_q.rw
    && (l_q.bit_cnt == 3'h1) && ~l_q.rx_done && (l_q.dcnt != 2'h0)
    && ~prot
    && ~(alarm && (l_q.dcnt == 2'h1));

  // ------------------------------------------------------------
  // Link sequencer
  // ------------------------------------------------------------
  always_comb begin
    logic ld_tx;
    logic ack;
    ld_tx = 1'b0;
    ack = 1'b0;
    l_d = l_q;
    l_d.scl_p = scl_s;
    l_d.sda_p = sda_s;
    l_d.pend = l_q.pend & ~busy_s;
    if (stop_c) begin
      // Address already loaded, so a bare stop sets the current address
      if (wr_ok) begin
        l_d.tgl = ~l_q.tgl;
        l_d.pend = 1'b1;
      end
      l_d.ph = PH_IDLE;
      l_d.oe = 1'b0;
      l_d.rx_done = 1'b0;
    end else if (start_c) begin
      // Counter is left alone on a repeated start
      l_d.ph = PH_RX;
      l_d.kind = K_SLV;
      l_d.bit_cnt = 3'h0;
      l_d.rx_done = 1'b0;
      l_d.oe = 1'b0;
    end else begin
      unique case (l_q.ph)
        PH_IDLE: begin
          l_d.oe = 1'b0;
        end
        PH_RX: begin
          if (rise) begin
            l_d.sh = {l_q.sh[6:0], sda_s};
            l_d.bit_cnt = l_q.bit_cnt + 3'h1;
            if (l_q.bit_cnt == 3'h7) begin
              l_d.rx_done = 1'b1;
            end
          end else if (fall && l_q.rx_done) begin
            l_d.rx_done = 1'b0;
            unique case (l_q.kind)
              K_SLV: begin
                ack = (id_arr | id_ccr) & ~busy_l;
                if (ack) begin
                  l_d.sec = id_ccr;
                  l_d.rw = l_q.sh[0];
                  l_d.kind = l_q.sh[0] ? K_SLV : K_AHI;
                  l_d.dcnt = 2'h0;
                  l_d.pmask = '0;
                end
              end
              K_AHI: begin
                ack = 1'b1;
                l_d.ahi = l_q.sh;
                l_d.kind = K_ALO;
              end
              K_ALO: begin
                ack = 1'b1;
                l_d.addr = full_addr;
                l_d.pbase = full_addr & ~pgmask;
                l_d.kind = K_DAT;
              end
              K_DAT: begin
                // Acked even when protected; commit is what gets refused
                ack = 1'b1;
                l_d.pbuf[{off, 3'h0} +: 8] = l_q.sh;
                l_d.pmask[off] = 1'b1;
                l_d.addr = wr_next;
                if (l_q.dcnt != 2'h2) begin
                  l_d.dcnt = l_q.dcnt + 2'h1;
                end
              end
            endcase
            l_d.oe = ack;
            l_d.ph = ack ? PH_ACK : PH_IDLE;
          end
        end
        PH_ACK: begin
          if (fall) begin
            l_d.oe = 1'b0;
            if ((l_q.kind == K_SLV) && l_q.rw) begin
              ld_tx = 1'b1;
            end else begin
              l_d.ph = PH_RX;
              l_d.bit_cnt = 3'h0;
            end
          end
        end
        PH_TX: begin
          if (fall) begin
            if (l_q.bit_cnt == 3'h7) begin
              l_d.oe = 1'b0;
              l_d.ph = PH_MACK;
              l_d.rx_done = 1'b0;
            end else begin
              l_d.sh = {l_q.sh[6:0], 1'b0};
              l_d.oe = ~l_q.sh[6];
              l_d.bit_cnt = l_q.bit_cnt + 3'h1;
            end
          end
        end
        PH_MACK: begin
          if (rise) begin
            if (sda_s) begin
              l_d.ph = PH_IDLE;
            end else begin
              l_d.rx_done = 1'b1;
            end
          end else if (fall && l_q.rx_done) begin
            l_d.rx_done = 1'b0;
            ld_tx = 1'b1;
          end
        end
        default: begin
          l_d.ph = PH_IDLE;
          l_d.oe = 1'b0;
        end
      endcase
    end
    if (ld_tx) begin
      l_d.sh = rd_byte;
      l_d.oe = ~rd_byte[7];
      l_d.bit_cnt = 3'h0;
      l_d.addr = rd_next;
      l_d.ph = PH_TX;
    end
  end

  // Reset clears the address counter to zero
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      l_q <= LINK_RST;
    end else begin
      l_q <= l_d;
    end
  end

  // ------------------------------------------------------------
  // Storage commit
  // ------------------------------------------------------------
  // Whole page written in one cycle; only loaded columns change
  always_ff @(posedge link_clk) begin
    if (!link_rst && stop_c && wr_ok) begin
      for (int i = 0; i < PAGE_MAX; i++) begin
        if (l_q.pmask[i]) begin
          if (l_q.sec) begin
            if (i < CCR_PAGE) begin
              ccr_mem[l_q.pbase[CCR_AW-1:0] | CCR_AW'(i)] <= l_q.pbuf[8*i +: 8];
            end
          end else begin
            arr_mem[l_q.pbase[ARR_AW-1:0] | ARR_AW'(i)] <= l_q.pbuf[8*i +: 8];
          end
        end
      end
    end
  end

  // Open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe = l_q.oe;
  assign addr_cnt = l_q.addr;
endmodule

// [src/rsa_sync.sv]
// Two-flop synchroniser for a bundle of independent levels.
// Assumes each bit is a level; words must not cross through it.
`timescale 1ns/1ps
module rsa_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } rsa_sync_type;

  rsa_sync_type sq_q;
  rsa_sync_type sq_d;

  // First stage feeds only the second
  always_comb begin
    sq_d.s1 = d;
    sq_d.s2 = sq_q.s1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sq_q <= '{s1: RST_VAL, s2: RST_VAL};
    end else begin
      sq_q <= sq_d;
    end
  end

  assign q = sq_q.s2;
endmodule

// [src/rsa_wtimer.sv]
// Non-volatile write cycle timer on the device clock.
// Assumes start is a one-cycle pulse already in the ref_clk domain.
`timescale 1ns/1ps
module rsa_wtimer
  import rsa_pkg::*;
#(
  parameter int CYCLES = WR_CYCLES_DFLT
)(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic start,
  output logic busy
);
  localparam int CW = $clog2(CYCLES + 1);

  if (CYCLES < 1) begin : g_bad_cycles
    $error("rsa_wtimer: CYCLES must be at least 1");
  end

  typedef struct packed {
    logic busy;
    logic [CW-1:0] cnt;
  } rsa_tmr_type;

  rsa_tmr_type t_q;
  rsa_tmr_type t_d;

  always_comb begin
    t_d = t_q;
    if (t_q.busy) begin
      if (t_q.cnt == '0) begin
        t_d.busy = 1'b0;
      end else begin
        t_d.cnt = t_q.cnt - 1'b1;
      end
    end else if (start) begin
      t_d.busy = 1'b1;
      t_d.cnt = CW'(CYCLES - 1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      t_q <= '0;
    end else begin
      t_q <= t_d;
    end
  end

  assign busy = t_q.busy;
endmodule
